// ---- bms_pkg.sv ----
package btmsel_pkg;
    // ------------------------------------------------------------
    // boot modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BTMSEL_MODE_NONE = 2'b00, // no boot, run from external memory
        BTMSEL_MODE_HOST = 2'b01, // boot from host processor
        BTMSEL_MODE_EPROM = 2'b10, // boot from 8-bit eprom
        BTMSEL_MODE_BAD = 2'b11 // illegal strap combination
    } btmsel_mode_t;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BTMSEL_ST_RESET = 2'b00, // reset held, straps watched
        BTMSEL_ST_START = 2'b01, // one cycle to launch at the vector
        BTMSEL_ST_RUN = 2'b10 // executing
    } btmsel_state_t;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int BTMSEL_EPROM_WIDTH = 8; // boot eprom data width
    localparam int BTMSEL_PC_WIDTH = 24; // program address width
    localparam logic [23:0] BTMSEL_RESET_VECTOR = 24'h020004;
    localparam int BTMSEL_TAP_STATE_WIDTH = 4; // test state width
    localparam logic [3:0] BTMSEL_TAP_RESET_STATE = 4'hf;
endpackage

// ---- bms_tap_reset.sv ----
`timescale 1ns/10ps
// holds a test access state register; forced to reset by test reset
module btmsel_tap_reset
    import btmsel_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // test reset, active low
    input wire logic test_rst_n_in,
    // next state from the test logic
    input wire logic [3:0] tap_next_in,
    // current state
    output logic [3:0] tap_state_out
);
    // --------------------------------------------------------
    // state register
    // --------------------------------------------------------
    // test reset is sampled like any input; no async path here
    always_ff @(posedge sys_clk_in) begin
        if (!test_rst_n_in) begin
            tap_state_out <= BTMSEL_TAP_RESET_STATE;
        end else begin
            tap_state_out <= tap_next_in;
        end
    end

    tap_rst_a: assert property (@(posedge sys_clk_in)
        !test_rst_n_in |=> tap_state_out == BTMSEL_TAP_RESET_STATE)
        else $error("test state not reset");
endmodule

// ---- bms_boot_select.sv ----
`timescale 1ns/10ps
module btmsel_boot_select
    import btmsel_pkg::*;
#(
    parameter int PC_WIDTH = BTMSEL_PC_WIDTH
)(
    // clock and resets
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic test_rst_n_in,
    // boot straps
    input wire logic eprom_boot_select_in,
    input wire logic link_boot_select_in,
    // boot memory select pin
    input wire logic boot_memory_select_in,
    output logic boot_memory_select_out,
    output logic boot_memory_select_oe_out,
    // boot control from the core
    input wire logic bus_master_in,
    input wire logic boot_cs_active_in,
    input wire logic boot_three_state_in,
    // test state machine
    input wire logic [3:0] tap_next_in,
    output logic [3:0] tap_state_out,
    // status to the core
    output logic [1:0] boot_mode_out,
    output logic boot_error_out,
    output logic running_out,
    output logic [PC_WIDTH-1:0] fetch_addr_out,
    output logic fetch_valid_out
);
    // ------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------
    // used only for the live decode that feeds the latch
    function automatic btmsel_mode_t decode_mode(input logic eb,
                                                 input logic lb,
                                                 input logic bm);
        if (eb) begin
            // link strap must be low; a high one is illegal
            if (lb) begin
                decode_mode = BTMSEL_MODE_BAD;
            end else begin
                decode_mode = BTMSEL_MODE_EPROM;
            end
        end else if (lb) begin
            decode_mode = BTMSEL_MODE_BAD; // link boot unsupported
        end else if (bm) begin
            decode_mode = BTMSEL_MODE_HOST;
        end else begin
            decode_mode = BTMSEL_MODE_NONE;
        end
    endfunction

    btmsel_mode_t mode_reg; // latched boot mode
    btmsel_state_t state_reg; // start-up sequencer
    logic [PC_WIDTH-1:0] pc_reg; // fetch address
    btmsel_mode_t strap_mode; // live decode of the straps

    assign strap_mode = decode_mode(eprom_boot_select_in,
                                    link_boot_select_in,
                                    boot_memory_select_in);

    // ------------------------------------------------------------
    // mode latch
    // ------------------------------------------------------------
    // follow the straps while reset is held, freeze at release so
    // a floating strap later on cannot switch the boot path
    always_ff @(posedge sys_clk_in) begin
        if (state_reg == BTMSEL_ST_RESET) begin
            mode_reg <= strap_mode;
        end
    end

    // ------------------------------------------------------------
    // start-up sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_reg <= BTMSEL_ST_RESET;
        end else begin
            unique case (state_reg)
                BTMSEL_ST_RESET: begin
                    state_reg <= BTMSEL_ST_START;
                end
                BTMSEL_ST_START: begin
                    state_reg <= BTMSEL_ST_RUN;
                end
                BTMSEL_ST_RUN: begin
                    state_reg <= BTMSEL_ST_RUN;
                end
                default: begin
                    state_reg <= BTMSEL_ST_RESET; // unused code
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // fetch address
    // ------------------------------------------------------------
    // one fetch per clock; no divider, so the rate is the clock's
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || state_reg == BTMSEL_ST_RESET) begin
            pc_reg <= PC_WIDTH'(BTMSEL_RESET_VECTOR);
            fetch_valid_out <= 1'b0;
        end else if (state_reg == BTMSEL_ST_START) begin
            pc_reg <= PC_WIDTH'(BTMSEL_RESET_VECTOR);
            fetch_valid_out <= 1'b1;
        end else begin
            pc_reg <= pc_reg + PC_WIDTH'(1);
            fetch_valid_out <= 1'b1;
        end
    end
    assign fetch_addr_out = pc_reg;

    // ------------------------------------------------------------
    // boot memory select pin
    // ------------------------------------------------------------
    // the pin is an input strap in every mode except eprom boot, so
    // the enable is never raised while reset holds the latch open
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || state_reg == BTMSEL_ST_RESET) begin
            boot_memory_select_oe_out <= 1'b0;
            boot_memory_select_out <= 1'b1;
        end else if (mode_reg == BTMSEL_MODE_EPROM && bus_master_in &&
                     !boot_three_state_in) begin
            boot_memory_select_oe_out <= 1'b1;
            boot_memory_select_out <= !boot_cs_active_in;
        end else begin
            boot_memory_select_oe_out <= 1'b0;
            boot_memory_select_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            running_out <= 1'b0;
            boot_error_out <= 1'b0;
            boot_mode_out <= BTMSEL_MODE_NONE;
        end else begin
            running_out <= (state_reg != BTMSEL_ST_RESET);
            boot_error_out <= (mode_reg == BTMSEL_MODE_BAD);
            boot_mode_out <= mode_reg;
        end
    end

    // ------------------------------------------------------------
    // test state machine
    // ------------------------------------------------------------
    btmsel_tap_reset u_tap (
        .sys_clk_in(sys_clk_in),
        .test_rst_n_in(test_rst_n_in),
        .tap_next_in(tap_next_in),
        .tap_state_out(tap_state_out)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence release_s;
        rst_in ##1 !rst_in;
    endsequence
    sequence launch_s;
        !fetch_valid_out ##1 fetch_valid_out &&
            fetch_addr_out == PC_WIDTH'(BTMSEL_RESET_VECTOR);
    endsequence

    // launch_s starts at the second edge after release: valid is
    // still low there and rises with the vector one edge later
    vector_start_a: assert property (@(posedge sys_clk_in)
        release_s ##1 !rst_in |-> launch_s)
        else $error("no start at reset vector");
    clk_rate_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        fetch_valid_out && $past(fetch_valid_out) && !$past(rst_in)
        |-> fetch_addr_out == $past(fetch_addr_out) + PC_WIDTH'(1))
        else $error("fetch did not advance one per clock");
    oe_mode_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        boot_memory_select_oe_out |-> mode_reg == BTMSEL_MODE_EPROM)
        else $error("pin driven outside eprom mode");
    master_only_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        boot_memory_select_oe_out |-> $past(bus_master_in))
        else $error("pin driven while not bus master");
    eprom_cs_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        state_reg == BTMSEL_ST_RUN && mode_reg == BTMSEL_MODE_EPROM &&
        bus_master_in && !boot_three_state_in
        |=> boot_memory_select_oe_out &&
            boot_memory_select_out == !$past(boot_cs_active_in))
        else $error("eprom chip select not driven");
    mode_hold_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        state_reg == BTMSEL_ST_RUN |=> $stable(mode_reg))
        else $error("boot mode changed after release");
    host_mode_a: assert property (@(posedge sys_clk_in)
        state_reg == BTMSEL_ST_RESET && !eprom_boot_select_in &&
        !link_boot_select_in && boot_memory_select_in
        |=> mode_reg == BTMSEL_MODE_HOST)
        else $error("host boot not selected");
    no_boot_a: assert property (@(posedge sys_clk_in)
        state_reg == BTMSEL_ST_RESET && !eprom_boot_select_in &&
        !link_boot_select_in && !boot_memory_select_in
        |=> mode_reg == BTMSEL_MODE_NONE)
        else $error("no-boot mode not selected");
    eprom_sel_a: assert property (@(posedge sys_clk_in)
        state_reg == BTMSEL_ST_RESET && eprom_boot_select_in &&
        !link_boot_select_in |=> mode_reg == BTMSEL_MODE_EPROM)
        else $error("eprom boot not selected");
endmodule

// ---- bms_pin_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// boot memory select pin and its board strap resistor
// ------------------------------------------------------------
module btmsel_pin_model (
    // what the device puts on the pin
    input wire logic drive_in,
    input wire logic oe_in,
    // level of the strap resistor
    input wire logic strap_in,
    // resolved pin level
    output logic pin_out
);
    // the strap only wins while the device is not driving the pin
    assign pin_out = oe_in ? drive_in : strap_in;
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
    import btmsel_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1; // held from time zero
    logic test_rst_n_in = 1'b0; // test reset low after power
    logic eb = 1'b0, lb = 1'b0, strap = 1'b1;
    logic bm = 1'b0, cs = 1'b0, ts = 1'b0;
    logic [3:0] tap_next = 4'h0;
    logic pin, pin_drive, pin_oe, err, run, fvalid;
    logic [3:0] tap_state;
    logic [1:0] mode;
    logic [23:0] faddr;
    int mismatches = 0;
    int checks_done = 0;

    // clock never stops
    initial begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    btmsel_pin_model pm (.drive_in(pin_drive), .oe_in(pin_oe),
        .strap_in(strap), .pin_out(pin));

    btmsel_boot_select dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .test_rst_n_in(test_rst_n_in), .eprom_boot_select_in(eb),
        .link_boot_select_in(lb), .boot_memory_select_in(pin),
        .boot_memory_select_out(pin_drive),
        .boot_memory_select_oe_out(pin_oe), .bus_master_in(bm),
        .boot_cs_active_in(cs), .boot_three_state_in(ts),
        .tap_next_in(tap_next), .tap_state_out(tap_state),
        .boot_mode_out(mode), .boot_error_out(err), .running_out(run),
        .fetch_addr_out(faddr), .fetch_valid_out(fvalid));

    // ------------------------------------------------------------
    // comparison and verdict
    // ------------------------------------------------------------
    task chk(input string what, input logic [23:0] exp,
             input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reset with given straps, release, then move the straps in run
    task boot(input logic e, input logic l, input logic s,
              input btmsel_mode_t m);
        @(negedge sys_clk_in);
        rst_in = 1'b1;
        eb = e;
        lb = l;
        strap = s;
        bm = 1'b0;
        cs = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk("reset run", 24'h0, {23'h0, run});
        chk("reset oe", 24'h0, {23'h0, pin_oe});
        rst_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk("mode", {22'h0, m}, {22'h0, mode});
        chk("error", {23'h0, m == BTMSEL_MODE_BAD}, {23'h0, err});
        chk("running", 24'h1, {23'h0, run});
        chk("valid", 24'h1, {23'h0, fvalid});
        chk("vector", BTMSEL_RESET_VECTOR, faddr);
        // straps change after release and must be ignored
        eb = ~e;
        lb = 1'b0;
        strap = ~s;
        repeat (3) @(negedge sys_clk_in);
        chk("held mode", {22'h0, m}, {22'h0, mode});
        chk("fetch rate", BTMSEL_RESET_VECTOR + 24'h3, faddr);
    endtask

    // set core pin controls, look one cycle later
    task pin_req(input logic m, input logic c, input logic t,
                 input logic exp_oe);
        bm = m;
        cs = c;
        ts = t;
        @(negedge sys_clk_in);
        chk("pin oe", {23'h0, exp_oe}, {23'h0, pin_oe});
        if (exp_oe)
            chk("chip select", {23'h0, ~c}, {23'h0, pin});
        else
            chk("pin idle", 24'h1, {23'h0, pin_drive});
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        mismatches++;
        close_out;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    // test reset: held state, one step, then back to reset
    task tap_reset_check;
        chk("tap reset", 24'hf, {20'h0, tap_state});
        test_rst_n_in = 1'b1;
        tap_next = 4'h3;
        @(negedge sys_clk_in);
        chk("tap step", 24'h3, {20'h0, tap_state});
        test_rst_n_in = 1'b0;
        @(negedge sys_clk_in);
        chk("tap again", 24'hf, {20'h0, tap_state});
        test_rst_n_in = 1'b1;
    endtask

    initial begin
        repeat (16) @(negedge sys_clk_in);
        tap_reset_check;
        // eprom mode: drive, release mastership, three-state
        boot(1'b1, 1'b0, 1'b1, BTMSEL_MODE_EPROM);
        pin_req(1'b1, 1'b1, 1'b0, 1'b1);
        pin_req(1'b1, 1'b0, 1'b0, 1'b1);
        pin_req(1'b0, 1'b1, 1'b0, 1'b0);
        pin_req(1'b1, 1'b1, 1'b1, 1'b0);
        // other modes never drive the pin
        boot(1'b0, 1'b0, 1'b1, BTMSEL_MODE_HOST);
        pin_req(1'b1, 1'b1, 1'b0, 1'b0);
        boot(1'b0, 1'b0, 1'b0, BTMSEL_MODE_NONE);
        pin_req(1'b1, 1'b1, 1'b0, 1'b0);
        boot(1'b0, 1'b1, 1'b1, BTMSEL_MODE_BAD);
        pin_req(1'b1, 1'b1, 1'b0, 1'b0);
        close_out;
    end
endmodule
